// [logic/timer0_pkg.sv]
// constants, register map and helper functions of the timer0 block
// How it works
// - count only while run_control is 1; hold the count otherwise.
// - after reset every timer0_control bit reads 1, so the timer runs.
// - width_select 1 gives an 8-bit counter, 0 gives a 16-bit counter.
// - source_select 0 counts instruction cycles, 1 counts pin transitions.
// - edge_select 1 counts falling pin edges, 0 counts rising pin edges.
// - prescaler_bypass 1 skips the prescaler; 0 clocks from its output.
// - prescale_field n divides by 2 to the power n+1, from 1:2 to 1:256.
// - timer mode without prescaler increments once every instruction cycle.
// - after a low count byte write, increments pause for two cycles.
// - the count pin is synchronised first, so the count lags the edge.
// - the prescaler is an 8-bit counter hidden from software.
// - a count write clears the prescaler and keeps prescaler_bypass.
// - prescaler assignment may change at any time while running.
// - overflow_flag sets on wrap FFh to 00h, or FFFFh to 0000h.
// - the overflow request is raised only while its enable bit is 1.
// - overflow_flag stays set until software clears it.
// - sleep stops the timer, so overflow cannot wake the processor.
// - in 16-bit mode a low byte read copies the true high byte to buffer.
// - in 16-bit mode a low byte write loads the true high byte from buffer.
`default_nettype none
package timer0_pkg;
    localparam int ADDR_W = 2;
    localparam int DATA_W = 8;
    localparam int PRESCALE_W = 8;
    localparam logic [1:0] OFF_CONTROL = 2'h0;
    localparam logic [1:0] OFF_COUNT_LOW = 2'h1;
    localparam logic [1:0] OFF_HIGH_BUFFER = 2'h2;
    localparam logic [1:0] OFF_INTERRUPT_CONTROL = 2'h3;
    localparam int BIT_RUN = 7;
    localparam int BIT_WIDTH8 = 6;
    localparam int BIT_SOURCE = 5;
    localparam int BIT_EDGE = 4;
    localparam int BIT_BYPASS = 3;
    localparam int BIT_ENABLE = 5;
    localparam int BIT_FLAG = 2;
    localparam logic [7:0] CONTROL_RESET = 8'hff;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] HIGH_BUFFER_RESET = 8'h00;
    localparam logic [1:0] INHIBIT_CYCLES = 2'h2;

    // mask of the prescaler bits that must all be one for an output tick
    function automatic logic [PRESCALE_W-1:0] ratio_mask(
        input logic [2:0] sel);
        logic [PRESCALE_W:0] wide;
        wide = (9'h002 << sel) - 9'h001;
        return wide[PRESCALE_W-1:0];
    endfunction : ratio_mask
endpackage : timer0_pkg
`default_nettype wire

// [logic/timer0_link_if.sv]
// carrier between the timer core and its prescaler
`timescale 1ns/10ps
`default_nettype none
interface timer0_link_if;
    logic raw_tick;
    logic [2:0] ratio;
    logic clear;
    logic out_tick;
    modport core(output raw_tick, output ratio, output clear,
        input out_tick);
    modport divider(input raw_tick, input ratio, input clear,
        output out_tick);
endinterface : timer0_link_if
`default_nettype wire

// [logic/pin_edge_sync.sv]
// synchroniser and edge detector for the external count pin
`timescale 1ns/10ps
`default_nettype none
module pin_edge_sync (
    input wire logic mclk,
    input wire logic rst,
    input wire logic external_count_pin,
    input wire logic edge_select,
    output logic tick
);
    logic s1;
    logic s2;
    logic s3;
    wire rise = s2 & ~s3;
    wire fall = ~s2 & s3;

    // s1 feeds only s2; the detector looks at s2 and s3
    always_ff @(posedge mclk) begin
        if (rst) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
        end else begin
            s1 <= external_count_pin;
            s2 <= s1;
            s3 <= s2;
        end
    end

    assign tick = edge_select ? fall : rise;

    property p_edge_lag;
        @(posedge mclk) disable iff (rst)
        tick |-> ($past(external_count_pin, 2)
            != $past(external_count_pin, 3))
            && ($past(external_count_pin, 2) == !edge_select);
    endproperty
    a_edge_lag: assert property (p_edge_lag)
        else $error("pin tick without matching delayed edge");
endmodule : pin_edge_sync
`default_nettype wire

// [logic/timer0_prescaler.sv]
// hidden power-of-two prescaler
`timescale 1ns/10ps
`default_nettype none
module timer0_prescaler #(
    parameter int WIDTH = timer0_pkg::PRESCALE_W
) (
    input wire logic mclk,
    input wire logic rst,
    timer0_link_if.divider link
);
    logic [WIDTH-1:0] count;
    wire [WIDTH-1:0] mask = timer0_pkg::ratio_mask(link.ratio);

    // no register port reaches count, software never sees it
    always_ff @(posedge mclk) begin
        if (rst || link.clear) begin
            count <= '0;
        end else if (link.raw_tick) begin
            count <= count + 1'b1;
        end
    end

    assign link.out_tick = link.raw_tick && ((count & mask) == mask);

    property p_clear_restart;
        @(posedge mclk) disable iff (rst)
        link.clear ##1 !link.clear |-> !link.out_tick;
    endproperty
    a_clear_restart: assert property (p_clear_restart)
        else $error("prescaler ticked right after being cleared");
endmodule : timer0_prescaler
`default_nettype wire

// [logic/timer0_timer_counter.sv]
// timer0 core: registers, count logic and overflow flag
//
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module timer0_timer_counter (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [timer0_pkg::ADDR_W-1:0] addr,
    input wire logic [timer0_pkg::DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [timer0_pkg::DATA_W-1:0] rdata,
    input wire logic external_count_pin,
    input wire logic sleep,
    output logic overflow_request
);
    logic [7:0] timer0_control;
    logic [7:0] count_low;
    logic [7:0] count_high;
    logic [7:0] timer0_count_high_buffer;
    logic overflow_flag;
    logic overflow_interrupt_enable;
    logic [1:0] inhibit;
    logic ext_tick;

    timer0_link_if link ();

    wire wr_ctrl = wr && (addr == timer0_pkg::OFF_CONTROL);
    wire wr_low = wr && (addr == timer0_pkg::OFF_COUNT_LOW);
    wire wr_high = wr && (addr == timer0_pkg::OFF_HIGH_BUFFER);
    wire wr_intc = wr && (addr == timer0_pkg::OFF_INTERRUPT_CONTROL);
    wire rd_low = rd && (addr == timer0_pkg::OFF_COUNT_LOW);
    wire width8 = timer0_control[timer0_pkg::BIT_WIDTH8];
    wire bypass = timer0_control[timer0_pkg::BIT_BYPASS];

    // sleep also freezes the prescaler, nothing can tick while asleep
    wire run = timer0_control[timer0_pkg::BIT_RUN] && !sleep;
    wire source_tick = timer0_control[timer0_pkg::BIT_SOURCE] ?
        ext_tick : 1'b1;
    assign link.raw_tick = run && source_tick;
    assign link.ratio = timer0_control[2:0];
    assign link.clear = wr_low;
    // bypass is read live each cycle, so reassignment needs no handshake
    wire inc_tick = (bypass ? link.raw_tick : link.out_tick)
        && (inhibit == 2'h0);
    wire wrap8 = (count_low == 8'hff);
    wire wrap16 = wrap8 && (count_high == 8'hff);
    wire overflow_event = inc_tick && (width8 ? wrap8 : wrap16);

    wire [7:0] next_count_low = wr_low ? wdata :
        inc_tick ? count_low + 8'h01 : count_low;
    wire [7:0] next_count_high = (wr_low && !width8) ?
        timer0_count_high_buffer :
        (inc_tick && !width8 && wrap8) ? count_high + 8'h01 :
        count_high;
    wire [7:0] next_high_buffer = wr_high ? wdata :
        (rd_low && !width8) ? count_high :
        timer0_count_high_buffer;
    // a wrap in the clearing cycle still leaves the flag set
    wire next_flag = overflow_event ||
        (wr_intc ? wdata[timer0_pkg::BIT_FLAG] : overflow_flag);
    wire [1:0] next_inhibit = wr_low ? timer0_pkg::INHIBIT_CYCLES :
        (inhibit != 2'h0) ? inhibit - 2'h1 : inhibit;

    wire [7:0] intc_view = {2'h0, overflow_interrupt_enable, 2'h0,
        overflow_flag, 2'h0};
    wire [7:0] read_mux =
        (addr == timer0_pkg::OFF_CONTROL) ? timer0_control :
        (addr == timer0_pkg::OFF_COUNT_LOW) ? count_low :
        (addr == timer0_pkg::OFF_HIGH_BUFFER) ? timer0_count_high_buffer :
        intc_view;

    pin_edge_sync u_sync (
        .mclk(mclk),
        .rst(rst),
        .external_count_pin(external_count_pin),
        .edge_select(timer0_control[timer0_pkg::BIT_EDGE]),
        .tick(ext_tick)
    );

    timer0_prescaler #(
        .WIDTH(timer0_pkg::PRESCALE_W)
    ) u_prescaler (
        .mclk(mclk),
        .rst(rst),
        .link(link)
    );

    always_ff @(posedge mclk) begin
        if (rst) begin
            timer0_control <= timer0_pkg::CONTROL_RESET;
        end else if (wr_ctrl) begin
            timer0_control <= wdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            count_low <= timer0_pkg::COUNT_RESET;
            count_high <= timer0_pkg::COUNT_RESET;
            timer0_count_high_buffer <= timer0_pkg::HIGH_BUFFER_RESET;
            inhibit <= 2'h0;
        end else begin
            count_low <= next_count_low;
            count_high <= next_count_high;
            timer0_count_high_buffer <= next_high_buffer;
            inhibit <= next_inhibit;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            overflow_flag <= 1'b0;
            overflow_interrupt_enable <= 1'b0;
        end else begin
            overflow_flag <= next_flag;
            if (wr_intc) begin
                overflow_interrupt_enable <= wdata[timer0_pkg::BIT_ENABLE];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata <= 8'h00;
        end else begin
            rdata <= rd ? read_mux : 8'h00;
        end
    end

    assign overflow_request = overflow_flag && overflow_interrupt_enable;

    property p_hold_when_off;
        @(posedge mclk) disable iff (rst)
        !timer0_control[timer0_pkg::BIT_RUN] && !wr_low |=> $stable(count_low);
    endproperty
    a_hold_when_off: assert property (p_hold_when_off)
        else $error("count moved while stopped");

    property p_reset_enabled;
        @(posedge mclk) rst |=> timer0_control == 8'hff;
    endproperty
    a_reset_enabled: assert property (p_reset_enabled)
        else $error("control not all ones after reset");

    property p_timer_every_cycle;
        @(posedge mclk) disable iff (rst)
        run && !timer0_control[timer0_pkg::BIT_SOURCE] && bypass
            && inhibit == 2'h0 && !wr_low
            |=> count_low == $past(count_low) + 8'h01;
    endproperty
    a_timer_every_cycle: assert property (p_timer_every_cycle)
        else $error("timer mode missed an instruction cycle");

    property p_inhibit_two;
        @(posedge mclk) disable iff (rst)
        wr_low ##1 !wr_low ##1 !wr_low |=> count_low == $past(wdata, 3);
    endproperty
    a_inhibit_two: assert property (p_inhibit_two)
        else $error("count moved within two cycles of a low write");

    property p_overflow_sets;
        @(posedge mclk) disable iff (rst)
        overflow_event && !wr_low |=> overflow_flag && count_low == 8'h00;
    endproperty
    a_overflow_sets: assert property (p_overflow_sets)
        else $error("wrap did not set the overflow flag");

    property p_flag_sticky;
        @(posedge mclk) disable iff (rst)
        overflow_flag && !wr_intc |=> overflow_flag;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("overflow flag dropped without software clear");

    property p_request_masked;
        @(posedge mclk) disable iff (rst)
        $rose(overflow_request) |-> overflow_interrupt_enable
            && $past(overflow_event || wr_intc);
    endproperty
    a_request_masked: assert property (p_request_masked)
        else $error("request rose without enable or cause");

    property p_sleep_stops;
        @(posedge mclk) disable iff (rst)
        sleep && !wr_low |=> $stable(count_low) && $stable(count_high);
    endproperty
    a_sleep_stops: assert property (p_sleep_stops)
        else $error("count moved during sleep");

    property p_read_copies;
        @(posedge mclk) disable iff (rst)
        rd_low && !width8 |=> timer0_count_high_buffer == $past(count_high);
    endproperty
    a_read_copies: assert property (p_read_copies)
        else $error("low read did not copy high byte");

    property p_write_loads;
        @(posedge mclk) disable iff (rst)
        wr_low && !width8 |=> count_high == $past(timer0_count_high_buffer);
    endproperty
    a_write_loads: assert property (p_write_loads)
        else $error("low write did not load high byte");

    property p_width8_high;
        @(posedge mclk) disable iff (rst)
        width8 |=> $stable(count_high);
    endproperty
    a_width8_high: assert property (p_width8_high)
        else $error("high byte changed in 8-bit mode");

    property p_high_carry;
        @(posedge mclk) disable iff (rst)
        inc_tick && !width8 && wrap8 && !wr_low
            |=> count_high == $past(count_high) + 8'h01;
    endproperty
    a_high_carry: assert property (p_high_carry)
        else $error("low byte wrap did not carry into high byte");

    // a clear racing a wrap must not lose the overflow
    property p_flag_set_wins;
        @(posedge mclk) disable iff (rst)
        overflow_event && wr_intc |=> overflow_flag;
    endproperty
    a_flag_set_wins: assert property (p_flag_set_wins)
        else $error("software clear beat a same-cycle overflow");

    property p_bypass_counts;
        @(posedge mclk) disable iff (rst)
        bypass && link.raw_tick && inhibit == 2'h0 && !wr_low
            |=> count_low == $past(count_low) + 8'h01;
    endproperty
    a_bypass_counts: assert property (p_bypass_counts)
        else $error("bypassed source tick did not count");

    property p_prescaled_waits;
        @(posedge mclk) disable iff (rst)
        !bypass && !link.out_tick && !wr_low |=> $stable(count_low);
    endproperty
    a_prescaled_waits: assert property (p_prescaled_waits)
        else $error("count moved without a prescaler output tick");
endmodule : timer0_timer_counter
`default_nettype wire

// [verif/pulse_source.sv]
// behavioural source of edges on the external count pin
`timescale 1ns/10ps
`default_nettype none
module pulse_source (
    input wire logic mclk,
    input wire logic rst,
    input wire logic start,
    input wire logic [3:0] toggles,
    input wire logic [3:0] hold,
    output logic pin,
    output logic busy
);
    logic [3:0] left;
    logic [3:0] cnt;
    // each level lasts hold+1 cycles, never under one cycle, so no edge is lost
    always_ff @(posedge mclk) begin
        if (rst) begin
            pin <= 1'b0;
            left <= 4'h0;
            cnt <= 4'h0;
        end else if (start && left == 4'h0) begin
            left <= toggles;
            cnt <= hold;
        end else if (left != 4'h0) begin
            if (cnt == 4'h0) begin
                pin <= ~pin;
                left <= left - 4'h1;
                cnt <= hold;
            end else begin
                cnt <= cnt - 4'h1;
            end
        end
    end
    assign busy = (left != 4'h0);
endmodule : pulse_source
`default_nettype wire

// [verif/tb.sv]
// self-checking bench for the timer0 block
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] addr = 2'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic sleep = 1'b0;
    logic start = 1'b0;
    logic [3:0] toggles = 4'h0;
    logic [3:0] hold = 4'h0;
    logic [7:0] rdata;
    logic [7:0] v1;
    logic [7:0] v2;
    logic pin;
    logic busy;
    logic overflow_request;
    int error_cnt = 0;
    int checks = 0;
    always #5 mclk = ~mclk;
    timer0_timer_counter timer0_timer_counter_inst (.mclk(mclk), .rst(rst),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .external_count_pin(pin), .sleep(sleep),
        .overflow_request(overflow_request));
    pulse_source pulse_source_inst (.mclk(mclk), .rst(rst), .start(start),
        .toggles(toggles), .hold(hold), .pin(pin), .busy(busy));
    task automatic results();
        if (error_cnt == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : results
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic wreg(input logic [1:0] a, input logic [7:0] d);
        @(posedge mclk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        wr <= 1'b0;
    endtask : wreg
    task automatic rreg(input logic [1:0] a, output logic [7:0] d);
        @(posedge mclk);
        rd <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rreg
    task automatic expect_reg(input logic [1:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rreg(a, d);
        check(d, exp);
    endtask : expect_reg
    // count lags the pin by the synchroniser, so allow a few cycles after
    task automatic pulses(input logic [3:0] t, input logic [3:0] h);
        @(posedge mclk);
        start <= 1'b1;
        toggles <= t;
        hold <= h;
        @(posedge mclk);
        start <= 1'b0;
        @(posedge mclk);
        while (busy === 1'b1) @(posedge mclk);
        repeat (4) @(posedge mclk);
    endtask : pulses
    initial begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        results();
    end
    initial begin
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        expect_reg(2'h0, 8'hff);
        expect_reg(2'h2, 8'h00);
        expect_reg(2'h3, 8'h00);
        wreg(2'h0, 8'h08);
        wreg(2'h2, 8'h5a);
        wreg(2'h1, 8'h00);
        wreg(2'h2, 8'h77);
        expect_reg(2'h2, 8'h77);
        expect_reg(2'h1, 8'h00);
        expect_reg(2'h2, 8'h5a);
        wreg(2'h3, 8'h20);
        wreg(2'h0, 8'hc8);
        wreg(2'h1, 8'hfd);
        repeat (8) @(posedge mclk);
        #1 check({7'h00, overflow_request}, 8'h01);
        wreg(2'h0, 8'h08);
        rreg(2'h1, v1);
        expect_reg(2'h2, 8'h5a);
        expect_reg(2'h3, 8'h24);
        wreg(2'h3, 8'h04);
        expect_reg(2'h3, 8'h04);
        check({7'h00, overflow_request}, 8'h00);
        wreg(2'h3, 8'h00);
        wreg(2'h3, 8'h20);
        expect_reg(2'h3, 8'h20);
        check({7'h00, overflow_request}, 8'h00);
        wreg(2'h3, 8'h00);
        wreg(2'h2, 8'hff);
        wreg(2'h1, 8'hfe);
        wreg(2'h0, 8'h88);
        repeat (8) @(posedge mclk);
        wreg(2'h0, 8'h08);
        expect_reg(2'h3, 8'h04);
        rreg(2'h1, v1);
        expect_reg(2'h2, 8'h00);
        wreg(2'h0, 8'hc8);
        wreg(2'h1, 8'h10);
        expect_reg(2'h1, 8'h10);
        expect_reg(2'h1, 8'h11);
        expect_reg(2'h1, 8'h13);
        // ratio is changed while running; window length is a multiple
        for (int i = 0; i < 8; i++) begin
            wreg(2'h0, 8'hc0 | i[7:0]);
            rreg(2'h1, v1);
            repeat ((4 << (i + 1)) - 2) @(posedge mclk);
            rreg(2'h1, v2);
            check(v2 - v1, 8'h04);
        end
        repeat (200) @(posedge mclk);
        wreg(2'h1, 8'h00);
        repeat (240) @(posedge mclk);
        expect_reg(2'h1, 8'h00);
        expect_reg(2'h0, 8'hc7);
        wreg(2'h0, 8'he8);
        wreg(2'h1, 8'h00);
        pulses(4'h3, 4'h0);
        expect_reg(2'h1, 8'h02);
        wreg(2'h0, 8'hf8);
        wreg(2'h1, 8'h00);
        pulses(4'h5, 4'h4);
        expect_reg(2'h1, 8'h03);
        wreg(2'h0, 8'hc8);
        @(posedge mclk);
        sleep <= 1'b1;
        rreg(2'h1, v1);
        repeat (10) @(posedge mclk);
        rreg(2'h1, v2);
        check(v2, v1);
        @(posedge mclk);
        sleep <= 1'b0;
        results();
    end
endmodule : tb
`default_nettype wire
